// File: src/ata_pins_device.sv
// ata device end: dma request, selects, strap role, read strobe handling
// assumes: one clock; pins synchronous to it; data bus resolved outside
// assumes: strap read once after reset; its pull-up makes open read high
// assumes: register banks held stable by firmware during a read
// Contract
// - device drives dma request to host
// - host drives dma acknowledge; input only
// - task file select addresses command block
// - control select addresses alt status/control
// - strap grounded master, open slave
// - strap held constant power-on to power-down
// - pio read strobe gates device read data
// - udma read: host asserts ready on strobe
// - ready negated pauses data-in words
// - read strobe meaning follows transfer mode
`timescale 1ns/10ps
`default_nettype none
module ata_pins_device
    import ata_pins_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    ata_pins_if.device pins,
    input wire logic [2:0] mode,
    input wire logic dev_is_slave_sel,
    input wire logic xfer_start,
    input wire logic [DATA_W-1:0] tf_rdata [8],
    input wire logic [DATA_W-1:0] cb_rdata [8],
    input wire logic [DATA_W-1:0] dma_word,
    output logic dma_word_taken,
    output logic is_master,
    output logic strap_valid,
    output logic busy
);
    // ****************************************************************
    // strap capture, after reset release
    // ****************************************************************
    logic strap_done_ff;
    logic master_ff;
    // grounded strap reads low: this unit is master
    wire nxt_master = !pins.cable_select;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_ff <= 1'b0;
        end else if (clk_en) begin
            strap_done_ff <= 1'b1;
        end
    end
    // caught once only; the strap must not move later
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            master_ff <= 1'b0;
        end else if (clk_en && !strap_done_ff) begin
            master_ff <= nxt_master;
        end
    end
    assign is_master = master_ff;
    assign strap_valid = strap_done_ff;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // both selects low is no decode, never a merged access
    function automatic logic [1:0] select_decode(
        input logic tf_n,
        input logic cb_n
    );
        logic [1:0] hit;
        hit = 2'b00;
        if (!tf_n && cb_n) begin
            hit = 2'b01;
        end else if (tf_n && !cb_n) begin
            hit = 2'b10;
        end
        return hit;
    endfunction : select_decode

    // bit 0: pio/mdma read strobe; bit 1: udma host ready
    function automatic logic [1:0] strobe_role(
        input logic [2:0] m,
        input logic strobe_n
    );
        logic [1:0] role;
        role = 2'b00;
        if (!strobe_n && m == MODE_UDMA) begin
            role = 2'b10;
        end else if (!strobe_n) begin
            role = 2'b01;
        end
        return role;
    endfunction : strobe_role

    // one bank of eight words, indexed by the register address
    function automatic logic [DATA_W-1:0] pick_word(
        input logic [DATA_W-1:0] bank [8],
        input logic [2:0] index
    );
        return bank[index];
    endfunction : pick_word

    // request rises only for the target unit and falls with the firmware ask
    function automatic logic next_request(
        input logic start,
        input logic target,
        input logic held
    );
        logic req;
        req = 1'b0;
        if (start) begin
            req = target || held;
        end
        return req;
    endfunction : next_request

    // any of the three read paths asks this unit to drive
    function automatic logic read_path(
        input logic pio,
        input logic burst,
        input logic mdma
    );
        return pio || burst || mdma;
    endfunction : read_path

    // ****************************************************************
    // decode
    // ****************************************************************
    logic dma_req_ff;
    // strap role against the unit that firmware names as target
    wire selected = strap_done_ff && (master_ff != dev_is_slave_sel);
    wire [1:0] sel_hit = select_decode(pins.task_file_select_n, pins.control_block_select_n);
    wire tf_hit = sel_hit[0];
    wire cb_hit = sel_hit[1];
    // one pin, two meanings, picked by the transfer mode
    wire [1:0] pin_role = strobe_role(mode, pins.read_strobe_n);
    wire pio_read = pin_role[0] && (tf_hit || cb_hit);
    wire udma_ready = pin_role[1];
    // acknowledge only counts while our own request stands
    wire dma_active = dma_req_ff && !pins.dma_ack_n;
    wire burst_go = dma_active && udma_ready;
    wire mdma_read = dma_active && pin_role[0];
    wire [DATA_W-1:0] tf_word = pick_word(tf_rdata, pins.reg_addr);
    wire [DATA_W-1:0] cb_word = pick_word(cb_rdata, pins.reg_addr);
    wire [DATA_W-1:0] pio_word = tf_hit ? tf_word : cb_word;

    // ****************************************************************
    // dma request
    // ****************************************************************
    wire nxt_dma_req = next_request(xfer_start, selected, dma_req_ff);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dma_req_ff <= 1'b0;
        end else if (clk_en) begin
            dma_req_ff <= nxt_dma_req;
        end
    end

    // ****************************************************************
    // bus drive and read data
    // ****************************************************************
    logic oe_n_ff;
    logic [DATA_W-1:0] dout_ff;
    // unselected or idle: bus stays released
    wire nxt_drive = selected && read_path(pio_read, burst_go, mdma_read);
    wire nxt_oe_n = !nxt_drive;
    // a register read wins the word path; dma words flow otherwise
    wire [DATA_W-1:0] nxt_dout = pio_read ? pio_word : dma_word;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            oe_n_ff <= 1'b1;
        end else if (clk_en) begin
            oe_n_ff <= nxt_oe_n;
        end
    end
    // data holds while released, so no stale word toggles the pins
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dout_ff <= DATA_RST;
        end else if (clk_en && nxt_drive) begin
            dout_ff <= nxt_dout;
        end
    end

    // ****************************************************************
    // word hand-back to the source
    // ****************************************************************
    logic taken_ff;
    // a paused burst takes no word
    wire nxt_taken = selected && (burst_go || mdma_read);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            taken_ff <= 1'b0;
        end else if (clk_en) begin
            taken_ff <= nxt_taken;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign pins.dma_req = dma_req_ff;
    assign pins.dev_data_out = dout_ff;
    assign pins.dev_data_oe_n = oe_n_ff;
    assign dma_word_taken = taken_ff;
    assign busy = dma_req_ff;
endmodule : ata_pins_device
`default_nettype wire

// File: src/ata_pins_pkg.sv
// package: constants shared by the ata control-pin device end and host end
// assumes: both ends run on one 250 MHz clock; pins sampled synchronously
package ata_pins_pkg;
    // ****************************************************************
    // widths and timing
    // ****************************************************************
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 4;
    // host strobe width in ns, and derived cycles (least time, rounded up)
    localparam int STROBE_NS = 16;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset values
    localparam logic RST_ACTIVE_LOW_HIGH = 1'b1;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // transfer mode, decides what the read strobe pin means
    typedef enum logic [2:0] {
        MODE_PIO = 3'b001,
        MODE_MDMA = 3'b010,
        MODE_UDMA = 3'b100
    } xfer_mode_e;

    // host sequencer states
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_PIO = 4'b0010,
        H_DMA = 4'b0100,
        H_DONE = 4'b1000
    } host_state_e;
endpackage : ata_pins_pkg

// File: src/ata_pins_if.sv
// interface: control pins between host controller and device
// assumes: testbench resolves the shared data bus from the enables
`timescale 1ns/10ps
`default_nettype none
interface ata_pins_if;
    import ata_pins_pkg::*;
    logic dma_req;
    logic dma_ack_n;
    logic task_file_select_n;
    logic control_block_select_n;
    logic read_strobe_n;
    logic [2:0] reg_addr;
    logic [DATA_W-1:0] dev_data_out;
    logic dev_data_oe_n;
    logic [DATA_W-1:0] data_in;
    logic cable_select;

    modport device (
        output dma_req, dev_data_out, dev_data_oe_n,
        input dma_ack_n, task_file_select_n, control_block_select_n,
        input read_strobe_n, reg_addr, data_in, cable_select
    );
    modport host (
        input dma_req, dev_data_out, dev_data_oe_n, data_in,
        output dma_ack_n, task_file_select_n, control_block_select_n,
        output read_strobe_n, reg_addr
    );
endinterface : ata_pins_if
`default_nettype wire

// File: src/ata_pins_host.sv
// ata host end: drives selects, read strobe / udma ready, dma acknowledge
// assumes: one clock; the device end samples the pins synchronously
`timescale 1ns/10ps
`default_nettype none
module ata_pins_host
    import ata_pins_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    ata_pins_if.host pins,
    input wire logic [2:0] mode,
    input wire logic reg_rd,
    input wire logic reg_is_ctrl,
    input wire logic [2:0] reg_index,
    input wire logic host_ready,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_valid
);
    // ****************************************************************
    // sequencer
    // ****************************************************************
    host_state_e st_ff;
    logic [7:0] cnt_ff;
    logic tf_n_ff, cb_n_ff, rd_n_ff, ack_n_ff;
    logic [2:0] addr_ff;
    logic [DATA_W-1:0] rd_data_ff;
    logic rd_valid_ff;
    wire got = !pins.dev_data_oe_n;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= H_IDLE;
            cnt_ff <= 8'h00;
            tf_n_ff <= 1'b1;
            cb_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            ack_n_ff <= 1'b1;
            addr_ff <= 3'h0;
            rd_data_ff <= DATA_RST;
            rd_valid_ff <= 1'b0;
        end else if (clk_en) begin
            rd_valid_ff <= 1'b0;
            case (st_ff)
                H_IDLE: begin
                    if (pins.dma_req) begin
                        ack_n_ff <= 1'b0;
                        st_ff <= H_DMA;
                    end else if (reg_rd) begin
                        tf_n_ff <= reg_is_ctrl;
                        cb_n_ff <= !reg_is_ctrl;
                        addr_ff <= reg_index;
                        rd_n_ff <= 1'b0;
                        cnt_ff <= 8'(STROBE_CYC);
                        st_ff <= H_PIO;
                    end
                end
                H_PIO: begin
                    if (cnt_ff != 8'h00) begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end else begin
                        rd_data_ff <= pins.data_in;
                        rd_valid_ff <= got;
                        rd_n_ff <= 1'b1;
                        tf_n_ff <= 1'b1;
                        cb_n_ff <= 1'b1;
                        st_ff <= H_DONE;
                    end
                end
                H_DMA: begin
                    // in udma the pin is host ready; negating it pauses
                    rd_n_ff <= (mode == MODE_UDMA) ? !host_ready : 1'b0;
                    if (got) begin
                        rd_data_ff <= pins.data_in;
                        rd_valid_ff <= 1'b1;
                    end
                    if (!pins.dma_req) begin
                        ack_n_ff <= 1'b1;
                        rd_n_ff <= 1'b1;
                        st_ff <= H_DONE;
                    end
                end
                H_DONE: st_ff <= H_IDLE;
                default: st_ff <= H_IDLE;
            endcase
        end
    end
    assign pins.task_file_select_n = tf_n_ff;
    assign pins.control_block_select_n = cb_n_ff;
    assign pins.read_strobe_n = rd_n_ff;
    assign pins.dma_ack_n = ack_n_ff;
    assign pins.reg_addr = addr_ff;
    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
endmodule : ata_pins_host
`default_nettype wire

// File: tb/ata_pins_assertions.sv
// checker: timing relations on the host/device control pins
// assumes: instantiated beside the interface; one clock, reset low
`timescale 1ns/10ps
`default_nettype none
module ata_pins_assertions (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic dma_req,
    input wire logic dma_ack_n,
    input wire logic task_file_select_n,
    input wire logic control_block_select_n,
    input wire logic read_strobe_n,
    input wire logic dev_data_oe_n
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cks @(posedge clock); endclocking
    default disable iff (!rst_b);
    // one cycle of lag: the device drives from what it saw last edge
    wire logic access = !dma_ack_n || !task_file_select_n || !control_block_select_n;
    wire logic pio_fall = dma_ack_n && !read_strobe_n;
    chk_ack_after_req: assert property ($fell(dma_ack_n) |-> $past(dma_req))
        else $error("acknowledge without request");
    chk_one_select: assert property (task_file_select_n || control_block_select_n)
        else $error("both selects low");
    chk_pio_has_sel: assert property ($fell(read_strobe_n) && dma_ack_n |-> access)
        else $error("read strobe without select");
    chk_strobe_width: assert property ($rose(pio_fall) |-> pio_fall [*4])
        else $error("read strobe too short");
    chk_drive_strobe: assert property (!dev_data_oe_n |-> !$past(read_strobe_n))
        else $error("bus driven without strobe");
    chk_drive_access: assert property (!dev_data_oe_n |-> $past(access))
        else $error("bus driven outside access");
    chk_release_bus: assert property ($rose(read_strobe_n) |=> dev_data_oe_n)
        else $error("bus not released");
    chk_ack_drops: assert property ($fell(dma_req) |-> ##[0:2] dma_ack_n)
        else $error("acknowledge held after request");
    cover property ($rose(pio_fall));
    cover property ($rose(dma_req));
    cover property (!dma_ack_n && $rose(read_strobe_n));
endmodule : ata_pins_assertions
`default_nettype wire

// File: tb/tb_ata_host_port_control_pins.sv
// testbench: host end and device end joined by the pin interface
// assumes: both ends on one 250 MHz clock; strap driven from here
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t: mismatch", $time); end end
module tb_ata_host_port_control_pins;
    import ata_pins_pkg::*;
    logic clock = 0, rst_b = 0, clk_en = 1, slv = 0, xfer_start = 0, reg_rd = 0, ctl = 0;
    logic host_ready = 0, dma_word_taken, is_master, strap_valid, busy, rd_valid, drove, sel_ok;
    logic [2:0] mode = MODE_PIO, idx = 0;
    logic [DATA_W-1:0] tf [8], cbk [8], dma_word = 0, rd_data;
    int miscompares = 0, comparisons = 0, seed = 6, n, taken;
    ata_pins_if bus();
    always #2 clock = ~clock;
    // released bus shows the inverse, never a stale copy
    assign bus.data_in = bus.dev_data_oe_n ? ~bus.dev_data_out : bus.dev_data_out;
    ata_pins_device i_ata_pins_device (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .pins(bus),
        .mode(mode), .dev_is_slave_sel(slv), .xfer_start(xfer_start), .tf_rdata(tf),
        .cb_rdata(cbk), .dma_word(dma_word), .dma_word_taken(dma_word_taken),
        .is_master(is_master), .strap_valid(strap_valid), .busy(busy));
    ata_pins_host i_ata_pins_host (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .pins(bus),
        .mode(mode), .reg_rd(reg_rd), .reg_is_ctrl(ctl), .reg_index(idx),
        .host_ready(host_ready), .rd_data(rd_data), .rd_valid(rd_valid));
    ata_pins_assertions i_ata_pins_assertions (.clock(clock), .rst_b(rst_b), .dma_req(bus.dma_req),
        .dma_ack_n(bus.dma_ack_n), .task_file_select_n(bus.task_file_select_n),
        .control_block_select_n(bus.control_block_select_n),
        .read_strobe_n(bus.read_strobe_n), .dev_data_oe_n(bus.dev_data_oe_n));
    // ****************************************************************
    // tasks
    // ****************************************************************
    function automatic logic [DATA_W-1:0] exp_reg(input logic c, input logic [2:0] i);
        return c ? cbk[i] : tf[i];
    endfunction : exp_reg
    task automatic final_report;
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic reg_read(input logic c, input logic [2:0] i, input logic drive);
        ctl = c;
        idx = i;
        reg_rd = 1;
        drove = 0;
        sel_ok = 0;
        @(negedge clock) reg_rd = 0;
        for (n = 0; n < 20 && rd_valid !== 1'b1; n++) begin
            @(negedge clock);
            drove |= !bus.dev_data_oe_n;
            if (!bus.read_strobe_n) sel_ok = bus.task_file_select_n === c
                && bus.control_block_select_n === !c && bus.reg_addr === i;
        end
        `CHK(rd_valid, drive)
        `CHK(sel_ok, 1'b1)
        `CHK(drove, drive)
        if (drive) `CHK(rd_data, exp_reg(c, i))
        repeat (3) @(negedge clock);
    endtask : reg_read
    task automatic dma_run(input logic [2:0] m);
        logic [DATA_W-1:0] w1;
        logic [DATA_W-1:0] w2;
        int words;
        mode = m;
        xfer_start = 1;
        host_ready = 1;
        taken = 0;
        words = 0;
        w1 = dma_word;
        w2 = dma_word;
        for (int k = 0; k < 40; k++) begin
            @(negedge clock);
            // a word loaded at one edge reaches rd_data two negedges later
            if (rd_valid === 1'b1) begin
                `CHK(rd_data, w2)
                words++;
            end
            w2 = w1;
            dma_word = DATA_W'($random(seed));
            w1 = dma_word;
            host_ready = !(k >= 20 && k < 28);
            if (k >= 24 && k < 28) taken += dma_word_taken;
        end
        `CHK(busy, 1'b1)
        `CHK(words > 0, 1'b1)
        `CHK(taken == 0, m == MODE_UDMA)
        xfer_start = 0;
        repeat (4) @(negedge clock);
        `CHK(bus.dma_req, 1'b0)
        `CHK(bus.dma_ack_n, 1'b1)
        mode = MODE_PIO;
    endtask : dma_run
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        bus.cable_select = 0; // grounded strap, held until the next reset
        for (int i = 0; i < 8; i++) begin
            tf[i] = DATA_W'($random(seed));
            cbk[i] = DATA_W'($random(seed));
        end
        repeat (2) @(negedge clock);
        rst_b = 1;
        repeat (2) @(negedge clock);
        `CHK(is_master, 1'b1)
        `CHK(strap_valid, 1'b1)
        reg_read(0, 7, 1);
        reg_read(1, 0, 1);
        repeat (8) reg_read(1'($random(seed)), 3'($random(seed)), 1);
        dma_run(MODE_UDMA);
        dma_run(MODE_MDMA);
        rst_b = 0;
        bus.cable_select = 1; // open strap, changed only under reset
        repeat (2) @(negedge clock);
        rst_b = 1;
        repeat (2) @(negedge clock);
        `CHK(is_master, 1'b0)
        `CHK(strap_valid, 1'b1)
        reg_read(0, 3, 0);
        slv = 1;
        reg_read(1, 5, 1);
        final_report;
    end
    initial begin
        #20000;
        miscompares++;
        final_report;
    end
endmodule : tb_ata_host_port_control_pins
`default_nettype wire
